// *** logic/cmd_decoder_defines.vh ***
// Constants for the command decoder of the eight-bank memory device.
// Assumes inclusion by bare name from logic/ design files.
`ifndef CMD_DECODER_DEFINES_VH
`define CMD_DECODER_DEFINES_VH
// Command codes (decoded command, 4 bits).
`define CMD_NONE 4'h0
`define CMD_ACTIVATE 4'h1
`define CMD_PRECHARGE 4'h2
`define CMD_PRECHARGE_ALL 4'h3
`define CMD_WRITE 4'h4
`define CMD_READ 4'h5
`define CMD_MODE_REG_WRITE 4'h6
`define CMD_REFRESH 4'h7
`define CMD_SELF_REFRESH_ENTRY 4'h8
`define CMD_SELF_REFRESH_EXIT 4'h9
`define CMD_POWER_DOWN_ENTRY 4'ha
`define CMD_POWER_DOWN_EXIT 4'hb
`define CMD_CAL_LONG 4'hc
`define CMD_CAL_SHORT 4'hd
`define CMD_ILLEGAL 4'he
// Power states.
`define PWR_NORMAL 2'h0
`define PWR_POWER_DOWN 2'h1
`define PWR_SELF_REFRESH 2'h2
// Address bit positions.
`define AUTO_CLOSE_BIT 10
`define BURST_CHOP_BIT 12
// Burst lengths in words.
`define FULL_EIGHT_WORDS 4'h8
`define CHOPPED_FOUR_WORDS 4'h4
// Internal clocks per core access of 8n bits.
`define CORE_CLOCKS 3'h4
// Reset values.
`define RESET_CMD 4'h0
`define RESET_BANK_OPEN 8'h00
`endif

// *** logic/link_edge_sync.v ***
// Two-flop synchroniser with rising edge detection for the link clock.
// Assumes clk_sys is much faster than the sampled link clock.
module link_edge_sync (
	input wire clk_sys,
	input wire reset_n,
	input wire link_in,
	output reg rise_pulse
);
	reg meta_q;
	reg sync_q;
	reg prev_q;

	// First flop feeds only the second; edge found on the settled copy.
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
			rise_pulse <= 1'b0;
		end
		else
		begin
			meta_q <= link_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
			rise_pulse <= sync_q & ~prev_q;
		end
	end
endmodule

// *** logic/ddr_cmd_decoder.v ***
// Command decoder and burst framer of an eight-bank memory device.
// Assumes all pins come from outside clk_sys and are sampled at link clock rise.
// Functional notes
// - Sample strobes at link clock rising edge only.
// - Decode uses previous and current clock enable.
// - Activate opens row in selected bank.
// - Legality judged on addressed bank state.
// - Column address gives burst start column.
// - Transfers are eight or four word bursts.
// - On-the-fly chop select picks burst form.
// - Auto close select closes bank as the burst starts.
// - Write decode: cs low, ras high, cas/we low.
// - Read decode: cs low, ras high, cas low, we high.
// - Mode register write only when all idle.
// - Power-down entry from idle on enable fall.
// - Power-down exit on enable rise with nop.
// - Mask pin blocks write data when high.
// - Termination strobe option disables data mask; here it forces write_data_enable low whatever the mask pin.
// - Core moves 8n bits over four clocks.
`include "cmd_decoder_defines.vh"
module ddr_cmd_decoder #(
	parameter BANKS = 8,
	parameter BANK_BITS = 3,
	parameter ADDR_BITS = 16,
	parameter COL_BITS = 10
) (
	input wire clk_sys,
	input wire reset_n,
	input wire link_clk,
	input wire cs_n,
	input wire ras_n,
	input wire cas_n,
	input wire we_n,
	input wire clk_enable,
	input wire [BANK_BITS-1:0] bank_select,
	input wire [ADDR_BITS-1:0] addr,
	input wire write_byte_mask,
	input wire on_the_fly_enable,
	input wire fixed_chop,
	input wire termination_strobe_enable,
	output reg [3:0] cmd_code,
	output reg cmd_valid,
	output reg cmd_illegal,
	output reg [BANK_BITS-1:0] cmd_bank,
	output reg [ADDR_BITS-1:0] row_addr,
	output reg [COL_BITS-1:0] start_col,
	output reg [3:0] burst_words,
	output reg auto_close,
	output reg [BANKS-1:0] bank_open,
	output reg [1:0] power_state,
	output reg [15:0] mode_opcode,
	output reg mode_opcode_valid,
	output reg cal_long,
	output reg write_data_enable,
	output reg termination_strobe,
	output reg [2:0] core_phase,
	output reg burst_active
);
	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	wire link_rise;
	reg [23+ADDR_BITS+BANK_BITS:0] pin_meta_q;
	reg [23+ADDR_BITS+BANK_BITS:0] pin_sync_q;
	wire [23+ADDR_BITS+BANK_BITS:0] pin_raw;
	reg cke_prev_q;
	reg [2:0] burst_left_q;

	// The link clock is found by edge detection in the system domain.
	link_edge_sync u_link_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.link_in(link_clk),
		.rise_pulse(link_rise)
	);

	assign pin_raw = {15'h0000, on_the_fly_enable, fixed_chop, termination_strobe_enable,
		write_byte_mask, clk_enable, cs_n, ras_n, cas_n, we_n, bank_select, addr};

	// Every pin passes two flops; the edge pulse lags three cycles, one more than the pins.
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_meta_q <= {(24+ADDR_BITS+BANK_BITS){1'b0}};
			pin_sync_q <= {(24+ADDR_BITS+BANK_BITS){1'b0}};
		end
		else
		begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
		end
	end

	wire [ADDR_BITS-1:0] s_addr = pin_sync_q[ADDR_BITS-1:0];
	wire [BANK_BITS-1:0] s_bank = pin_sync_q[ADDR_BITS+BANK_BITS-1:ADDR_BITS];
	wire s_we_n = pin_sync_q[ADDR_BITS+BANK_BITS];
	wire s_cas_n = pin_sync_q[ADDR_BITS+BANK_BITS+1];
	wire s_ras_n = pin_sync_q[ADDR_BITS+BANK_BITS+2];
	wire s_cs_n = pin_sync_q[ADDR_BITS+BANK_BITS+3];
	wire s_cke = pin_sync_q[ADDR_BITS+BANK_BITS+4];
	wire s_mask = pin_sync_q[ADDR_BITS+BANK_BITS+5];
	wire s_termination_strobe_en = pin_sync_q[ADDR_BITS+BANK_BITS+6];
	wire s_fixed_chop = pin_sync_q[ADDR_BITS+BANK_BITS+7];
	wire s_otf_en = pin_sync_q[ADDR_BITS+BANK_BITS+8];

	// ************************************************************
	// Command decode
	// ************************************************************
	reg [3:0] cmd_d;
	reg all_idle;
	reg nop_or_desel;
	reg sel_open;

	// Strobe pattern plus both enable levels form the command.
	always @*
	begin
		all_idle = (bank_open == {BANKS{1'b0}});
		sel_open = bank_open[s_bank];
		nop_or_desel = s_cs_n | (s_ras_n & s_cas_n & s_we_n);
		cmd_d = `CMD_NONE;
		if (power_state != `PWR_NORMAL)
		begin
			// Only a rising enable with nop or deselect leaves low power.
			if (!cke_prev_q && s_cke && nop_or_desel)
				cmd_d = (power_state == `PWR_SELF_REFRESH) ? `CMD_SELF_REFRESH_EXIT
					: `CMD_POWER_DOWN_EXIT;
		end
		else if (cke_prev_q && !s_cke)
		begin
			if (nop_or_desel)
				cmd_d = all_idle ? `CMD_POWER_DOWN_ENTRY : `CMD_ILLEGAL;
			else if (!s_ras_n && !s_cas_n && s_we_n && all_idle)
				cmd_d = `CMD_SELF_REFRESH_ENTRY;
			else
				cmd_d = `CMD_ILLEGAL;
		end
		else if (cke_prev_q && s_cke && !s_cs_n)
		begin
			case ({s_ras_n, s_cas_n, s_we_n})
				3'h3: cmd_d = sel_open ? `CMD_ILLEGAL : `CMD_ACTIVATE;
				3'h2: cmd_d = s_addr[`AUTO_CLOSE_BIT] ? `CMD_PRECHARGE_ALL
					: `CMD_PRECHARGE;
				3'h4: cmd_d = sel_open ? `CMD_WRITE : `CMD_ILLEGAL;
				3'h5: cmd_d = sel_open ? `CMD_READ : `CMD_ILLEGAL;
				3'h0: cmd_d = all_idle ? `CMD_MODE_REG_WRITE : `CMD_ILLEGAL;
				3'h1: cmd_d = all_idle ? `CMD_REFRESH : `CMD_ILLEGAL;
				3'h6: cmd_d = !all_idle ? `CMD_ILLEGAL
					: (s_addr[`AUTO_CLOSE_BIT] ? `CMD_CAL_LONG : `CMD_CAL_SHORT);
				default: cmd_d = `CMD_NONE;
			endcase
		end
	end

	// ************************************************************
	// State update at each sampled link clock rise
	// ************************************************************
	// Registers other than the two valid pulses act only on the link rise pulse, so pins are seen once per edge.
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cke_prev_q <= 1'b0;
			cmd_code <= `RESET_CMD;
			cmd_valid <= 1'b0;
			cmd_illegal <= 1'b0;
			cmd_bank <= {BANK_BITS{1'b0}};
			row_addr <= {ADDR_BITS{1'b0}};
			start_col <= {COL_BITS{1'b0}};
			burst_words <= `FULL_EIGHT_WORDS;
			auto_close <= 1'b0;
			bank_open <= `RESET_BANK_OPEN;
			power_state <= `PWR_NORMAL;
			mode_opcode <= 16'h0000;
			mode_opcode_valid <= 1'b0;
			cal_long <= 1'b0;
			write_data_enable <= 1'b0;
			termination_strobe <= 1'b0;
			core_phase <= 3'h0;
			burst_active <= 1'b0;
			burst_left_q <= 3'h0;
		end
		else
		begin
			cmd_valid <= 1'b0;
			mode_opcode_valid <= 1'b0;
			if (link_rise)
			begin
				cke_prev_q <= s_cke;
				cmd_code <= cmd_d;
				cmd_valid <= (cmd_d != `CMD_NONE);
				cmd_illegal <= (cmd_d == `CMD_ILLEGAL);
				cmd_bank <= s_bank;
				// Mask pin serves as termination strobe when enabled.
				termination_strobe <= s_termination_strobe_en & s_mask;
				write_data_enable <= !s_termination_strobe_en && cke_prev_q && !all_idle
					&& !s_mask;
				// Core moves the 8n prefetch over four internal clocks.
				if (burst_left_q != 3'h0)
				begin
					burst_left_q <= burst_left_q - 3'h1;
					core_phase <= core_phase + 3'h1;
				end
				else
				begin
					burst_active <= 1'b0;
					core_phase <= 3'h0;
				end
				case (cmd_d)
					`CMD_ACTIVATE:
					begin
						bank_open[s_bank] <= 1'b1;
						row_addr <= s_addr;
					end
					`CMD_PRECHARGE: bank_open[s_bank] <= 1'b0;
					`CMD_PRECHARGE_ALL: bank_open <= {BANKS{1'b0}};
					`CMD_WRITE, `CMD_READ:
					begin
						start_col <= s_addr[COL_BITS-1:0];
						auto_close <= s_addr[`AUTO_CLOSE_BIT];
						if (s_otf_en)
							burst_words <= s_addr[`BURST_CHOP_BIT] ? `FULL_EIGHT_WORDS
								: `CHOPPED_FOUR_WORDS;
						else
							burst_words <= s_fixed_chop ? `CHOPPED_FOUR_WORDS
								: `FULL_EIGHT_WORDS;
						burst_active <= 1'b1;
						core_phase <= 3'h0;
						burst_left_q <= `CORE_CLOCKS - 3'h1;
						// Auto close shuts the bank once the burst is framed.
						if (s_addr[`AUTO_CLOSE_BIT])
							bank_open[s_bank] <= 1'b0;
					end
					`CMD_MODE_REG_WRITE:
					begin
						mode_opcode <= s_addr;
						mode_opcode_valid <= 1'b1;
					end
					`CMD_CAL_LONG: cal_long <= 1'b1;
					`CMD_CAL_SHORT: cal_long <= 1'b0;
					`CMD_POWER_DOWN_ENTRY: power_state <= `PWR_POWER_DOWN;
					`CMD_SELF_REFRESH_ENTRY: power_state <= `PWR_SELF_REFRESH;
					`CMD_POWER_DOWN_EXIT, `CMD_SELF_REFRESH_EXIT:
						power_state <= `PWR_NORMAL;
					default: cal_long <= cal_long;
				endcase
			end
		end
	end
endmodule

// *** sim/ddr_cmd_decoder_chk.sv ***
// Concurrent checks on the decoder ports: pulses, bank map, framing.
// Assumes it is bound to every instance of ddr_cmd_decoder.
module ddr_cmd_decoder_chk #(
	parameter BANKS = 8,
	parameter BANK_BITS = 3
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [3:0] cmd_code,
	input wire logic cmd_valid,
	input wire logic cmd_illegal,
	input wire logic [BANK_BITS-1:0] cmd_bank,
	input wire logic [3:0] burst_words,
	input wire logic [BANKS-1:0] bank_open,
	input wire logic [1:0] power_state,
	input wire logic mode_opcode_valid,
	input wire logic [2:0] core_phase
);
	timeunit 1ns;
	timeprecision 1ps;
	// *****************************
	// All checks share one clock.
	// *****************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	a_valid_one_cycle: assert property (cmd_valid |=> !cmd_valid)
		else $error("Command pulse longer than one cycle.");
	a_map_moves_cmd: assert property ($changed(bank_open) |-> cmd_valid)
		else $error("Bank map changed without a command.");
	a_activate_opens: assert property (cmd_valid && cmd_code == 4'h1 |-> bank_open[cmd_bank])
		else $error("Activate left its bank closed.");
	a_illegal_inert: assert property (cmd_valid && cmd_code == 4'he |->
		cmd_illegal && $stable(bank_open) && $stable(power_state))
		else $error("Refused command changed state.");
	a_burst_length: assert property (burst_words == 4'h8 || burst_words == 4'h4)
		else $error("Burst length neither eight nor four.");
	a_mode_pulse: assert property (mode_opcode_valid |-> cmd_valid && cmd_code == 4'h6)
		else $error("Opcode pulse without mode write.");
	a_power_moves: assert property ($changed(power_state) |->
		cmd_valid && cmd_code inside {4'h8, 4'h9, 4'ha, 4'hb})
		else $error("Power state changed without entry or exit.");
	a_close_all: assert property (cmd_valid && cmd_code == 4'h3 |-> bank_open == '0)
		else $error("Precharge all left a bank open.");
	a_core_phase: assert property (core_phase <= 3'h3)
		else $error("Core phase beyond four clocks.");
endmodule
bind ddr_cmd_decoder ddr_cmd_decoder_chk #(.BANKS(BANKS), .BANK_BITS(BANK_BITS)) u_chk (
	.clk_sys(clk_sys), .reset_n(reset_n), .cmd_code(cmd_code), .cmd_valid(cmd_valid),
	.cmd_illegal(cmd_illegal), .cmd_bank(cmd_bank), .burst_words(burst_words),
	.bank_open(bank_open), .power_state(power_state),
	.mode_opcode_valid(mode_opcode_valid), .core_phase(core_phase));

// *** sim/ddr_ctrl_model.sv ***
// Controller model: sets command pins, then gives one link clock period.
// Assumes clk_sys runs; the link clock stands low between commands.
module ddr_ctrl_model (
	input wire logic clk_sys,
	output logic link_clk,
	output logic [3:0] cmd_pins,
	output logic cke,
	output logic [2:0] bank,
	output logic [15:0] adr
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle with deselect and the enable low.
	initial
	begin
		link_clk = 1'b0;
		cmd_pins = 4'hf;
		cke = 1'b0;
		bank = 3'h0;
		adr = 16'h0000;
	end
	// Pins settle ten cycles before the rise and hold for the whole period.
	task automatic send(input logic [3:0] p, input logic e, input logic [2:0] b,
		input logic [15:0] v);
		@(posedge clk_sys);
		#1;
		cmd_pins = p;
		cke = e;
		bank = b;
		adr = v;
		repeat (10) @(posedge clk_sys);
		#1 link_clk = 1'b1;
		repeat (10) @(posedge clk_sys);
		#1 link_clk = 1'b0;
	endtask
endmodule

// *** sim/ddr_cmd_decoder_tb.sv ***
// Bench for the command decoder, driven through the controller model.
// Assumes the checker is bound in its own file.
module ddr_cmd_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic mask = 1'b0;
	logic otf = 1'b1;
	logic fchop = 1'b0;
	logic termination_strobe_en = 1'b0;
	wire link_clk;
	wire cke;
	wire [3:0] pins;
	wire [2:0] bank;
	wire [15:0] adr;
	wire [3:0] cmd_code;
	wire [3:0] burst_words;
	wire [7:0] bank_open;
	wire [1:0] power_state;
	wire [9:0] start_col;
	wire [15:0] row_addr;
	wire [15:0] mode_opcode;
	wire cmd_valid;
	wire cmd_illegal;
	wire auto_close;
	wire cal_long;
	wire wde;
	wire tstrb;
	wire bact;
	int err_total = 0;
	int compares = 0;
	// Free running system clock.
	always #2 clk_sys = ~clk_sys;
	ddr_ctrl_model ctrl (.clk_sys(clk_sys), .link_clk(link_clk), .cmd_pins(pins),
		.cke(cke), .bank(bank), .adr(adr));
	ddr_cmd_decoder DUT (.clk_sys(clk_sys), .reset_n(reset_n), .link_clk(link_clk),
		.cs_n(pins[3]), .ras_n(pins[2]), .cas_n(pins[1]), .we_n(pins[0]),
		.clk_enable(cke), .bank_select(bank), .addr(adr), .write_byte_mask(mask),
		.on_the_fly_enable(otf), .fixed_chop(fchop), .termination_strobe_enable(termination_strobe_en),
		.cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_illegal(cmd_illegal),
		.cmd_bank(), .row_addr(row_addr), .start_col(start_col), .burst_words(burst_words),
		.auto_close(auto_close), .bank_open(bank_open), .power_state(power_state),
		.mode_opcode(mode_opcode), .mode_opcode_valid(), .cal_long(cal_long),
		.write_data_enable(wde), .termination_strobe(tstrb), .core_phase(),
		.burst_active(bact));
	task automatic final_report();
		$display("err_total %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Sends one command and waits a bounded time for its decode pulse.
	task automatic op(input logic [3:0] p, input logic e, input logic [2:0] b,
		input logic [15:0] v, input logic [3:0] code);
		int n;
		n = 0;
		fork
			ctrl.send(p, e, b, v);
			if (code != 4'h0)
			begin
				while (n < 30 && cmd_valid !== 1'b1)
				begin
					tick(1);
					n++;
				end
				if (n == 30)
				begin
					err_total++;
					final_report();
				end
				else
					chk(16'(cmd_code), 16'(code));
			end
		join
	endtask
	// Main command sequence.
	initial
	begin
		tick(2);
		reset_n = 1'b1;
		op(4'h7, 1'b1, 3'h0, 16'h0000, 4'h0);
		op(4'h7, 1'b1, 3'h0, 16'h0000, 4'h0);
		op(4'h0, 1'b1, 3'h2, 16'h1234, 4'h6);
		chk(mode_opcode, 16'h1234);
		op(4'h6, 1'b1, 3'h0, 16'h0400, 4'hc);
		chk(16'(cal_long), 16'h0001);
		op(4'h3, 1'b1, 3'h3, 16'h0abc, 4'h1);
		chk(16'(bank_open), 16'h0008);
		chk(row_addr, 16'h0abc);
		op(4'h0, 1'b1, 3'h0, 16'h0000, 4'he);
		chk(16'(cmd_illegal), 16'h0001);
		op(4'h5, 1'b1, 3'h5, 16'h0000, 4'he);
		op(4'h4, 1'b1, 3'h3, 16'h0015, 4'h4);
		chk(16'(burst_words), 16'h0004);
		chk(16'(start_col), 16'h0015);
		chk(16'(wde), 16'h0001);
		// The link clock stands still between commands, so a no-operation gives the edge.
		mask = 1'b1;
		op(4'h7, 1'b1, 3'h0, 16'h0000, 4'h0);
		chk(16'(wde), 16'h0000);
		termination_strobe_en = 1'b1;
		op(4'h7, 1'b1, 3'h0, 16'h0000, 4'h0);
		chk(16'(tstrb), 16'h0001);
		mask = 1'b0;
		op(4'h7, 1'b1, 3'h0, 16'h0000, 4'h0);
		chk(16'(wde), 16'h0000);
		termination_strobe_en = 1'b0;
		op(4'h5, 1'b1, 3'h3, 16'h1400, 4'h5);
		chk(16'(burst_words), 16'h0008);
		chk(16'(auto_close), 16'h0001);
		chk(16'(bank_open), 16'h0000);
		chk(16'(bact), 16'h0001);
		otf = 1'b0;
		fchop = 1'b1;
		op(4'h3, 1'b1, 3'h3, 16'h0001, 4'h1);
		op(4'h5, 1'b1, 3'h3, 16'h1000, 4'h5);
		chk(16'(burst_words), 16'h0004);
		fchop = 1'b0;
		op(4'h5, 1'b1, 3'h3, 16'h0000, 4'h5);
		chk(16'(burst_words), 16'h0008);
		op(4'h3, 1'b1, 3'h7, 16'h0002, 4'h1);
		chk(16'(bank_open), 16'h0088);
		op(4'h2, 1'b1, 3'h3, 16'h0000, 4'h2);
		chk(16'(bank_open), 16'h0080);
		op(4'h2, 1'b1, 3'h0, 16'h0400, 4'h3);
		op(4'h1, 1'b1, 3'h0, 16'h0000, 4'h7);
		chk(16'(bact), 16'h0000);
		op(4'h7, 1'b0, 3'h0, 16'h0000, 4'ha);
		chk(16'(power_state), 16'h0001);
		op(4'h7, 1'b1, 3'h0, 16'h0000, 4'hb);
		chk(16'(power_state), 16'h0000);
		op(4'h1, 1'b0, 3'h0, 16'h0000, 4'h8);
		chk(16'(power_state), 16'h0002);
		op(4'hf, 1'b1, 3'h0, 16'h0000, 4'h9);
		chk(16'(power_state), 16'h0000);
		op(4'h6, 1'b1, 3'h0, 16'h0000, 4'hd);
		chk(16'(cal_long), 16'h0000);
		final_report();
	end
endmodule
